// >>> common/wdt_consts.vh
// Constants for the watchdog timer core
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH
`define WDT_CNT_W 15
`define WDT_CNT_RELOAD 15'h7FFF
`define WDT_PRE_W 7
`define WDT_DIV16 7'h0F
`define WDT_DIV128 7'h7F
`define WDT_DIV2 7'h01
`define WDT_REFRESH_FIRST 8'h00
`define WDT_REFRESH_SECOND 8'hFF
// Word addresses (byte address = 4 * index), chosen layout
`define WDT_ADR_DETECT 3'h0
`define WDT_ADR_PROT 3'h1
`define WDT_ADR_REFRESH 3'h2
`define WDT_ADR_START 3'h3
`define WDT_ADR_CTRL 3'h4
`define WDT_ADR_IRQ_STAT 3'h5
`define WDT_ADR_IRQ_EN 3'h6
`define WDT_ADR_IRQ_CLR 3'h7
// Field positions
`define WDT_CTRL_PRESEL 7
`define WDT_CTRL_MODE 6
`define WDT_DETECT_BIT 3
`define WDT_PROT_BIT 7
`endif

// >>> src/wdt_prescaler.v
// Prescaler producing one-cycle count ticks
`include "wdt_consts.vh"
`default_nettype none
module wdt_prescaler (
  input wire clk_i,
  input wire rst_i,
  input wire run_i,
  input wire src_en_i,
  input wire presel_i,
  input wire sub_clk_i,
  input wire clr_i,
  output reg tick_o
);
  reg [`WDT_PRE_W-1:0] cnt_q;
  reg [`WDT_PRE_W-1:0] lim;
  // Ratio choice, sub clock overrides
  always @*
  begin
    if (sub_clk_i)
      lim = `WDT_DIV2;
    else if (presel_i)
      lim = `WDT_DIV128;
    else
      lim = `WDT_DIV16;
  end
  // Divider counting source enables
  always @(posedge clk_i)
  begin
    tick_o <= 1'b0;
    if (rst_i || clr_i)
      cnt_q <= {`WDT_PRE_W{1'b0}};
    else if (run_i && src_en_i)
    begin
      if (cnt_q >= lim)
      begin
        cnt_q <= {`WDT_PRE_W{1'b0}};
        tick_o <= 1'b1;
      end
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> src/wdt_counter.v
// Fifteen-bit down-counter with reload
`include "wdt_consts.vh"
`default_nettype none
module wdt_counter (
  input wire clk_i,
  input wire rst_i,
  input wire tick_i,
  input wire reload_i,
  output reg [`WDT_CNT_W-1:0] cnt_o,
  output reg uflow_o
);
  // Decrement, reload on refresh, reset or underflow
  always @(posedge clk_i)
  begin
    uflow_o <= 1'b0;
    if (rst_i || reload_i)
      cnt_o <= `WDT_CNT_RELOAD;
    else if (tick_i)
    begin
      if (cnt_o == {`WDT_CNT_W{1'b0}})
      begin
        cnt_o <= `WDT_CNT_RELOAD;
        uflow_o <= 1'b1;
      end
      else
        cnt_o <= cnt_o - 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> src/wdt_core.v
// Watchdog timer core with Wishbone register slave
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`include "wdt_consts.vh"
`default_nettype none
module wdt_core (
  input wire clk_i,
  input wire rst_i,
  input wire [4:2] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  input wire auto_start_option_i,
  input wire protection_option_bit_i,
  input wire sub_clock_select_i,
  input wire low_speed_osc_clock_i,
  input wire stop_mode_i,
  input wire wait_mode_i,
  input wire bus_hold_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg wdt_nmi_o,
  output reg wdt_reset_o,
  output reg irq_o
);
  localparam ST_STOPPED = 1'b0;
  localparam ST_RUNNING = 1'b1;
  reg state_q;
  reg prescaler_select_q;
  reg mode_reset_q;
  reg prot_reg_q;
  reg prot_armed_q;
  reg refresh_armed_q;
  reg detect_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_en_q;
  reg [`WDT_CNT_W-1:0] cnt_snap;
  reg [31:0] dat_o_d;
  reg osc_q;
  wire [`WDT_CNT_W-1:0] cnt;
  wire tick;
  wire uflow;
  wire prot;
  wire halted;
  wire wr;
  wire rd;
  wire lane0;
  wire refresh_hit;
  wire src_en;
  wire run;
  // Protection mode from either request
  assign prot = protection_option_bit_i | prot_reg_q;
  // Low-power states stop the count only unprotected
  assign halted = ~prot & (stop_mode_i | wait_mode_i | bus_hold_i);
  assign run = (state_q == ST_RUNNING) & ~halted;
  // Protected: slow oscillator edge gives one-cycle source enable, else always enabled
  assign src_en = prot ? (low_speed_osc_clock_i & ~osc_q) : 1'b1;
  assign wr = cyc_i & stb_i & we_i & ~ack_o;
  assign rd = cyc_i & stb_i & ~we_i & ~ack_o;
  assign lane0 = sel_i[0];
  assign refresh_hit = wr & lane0 & (adr_i == `WDT_ADR_REFRESH) & refresh_armed_q
    & (dat_i[7:0] == `WDT_REFRESH_SECOND);

  wdt_prescaler u_pre (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .src_en_i(src_en),
    .presel_i(prescaler_select_q),
    .sub_clk_i(sub_clock_select_i),
    .clr_i(refresh_hit),
    .tick_o(tick)
  );

  wdt_counter u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .reload_i(refresh_hit),
    .cnt_o(cnt),
    .uflow_o(uflow)
  );

  // Oscillator sample for edge detection
  always @(posedge clk_i)
  begin
    if (rst_i)
      osc_q <= 1'b0;
    else
      osc_q <= low_speed_osc_clock_i;
  end

  // Start state machine
  always @(posedge clk_i)
  begin
    if (rst_i)
      state_q <= ST_STOPPED;
    else
    begin
      case (state_q)
        ST_STOPPED:
        begin
          if (auto_start_option_i)
            state_q <= ST_RUNNING;
          else if (wr && lane0 && adr_i == `WDT_ADR_START)
            state_q <= ST_RUNNING;
        end
        ST_RUNNING:
          state_q <= ST_RUNNING;
        default:
          state_q <= ST_STOPPED;
      endcase
    end
  end

  // Control, protection and refresh sequence state
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prescaler_select_q <= 1'b0;
      mode_reset_q <= 1'b0;
      prot_reg_q <= 1'b0;
      prot_armed_q <= 1'b0;
      refresh_armed_q <= 1'b0;
    end
    else if (wr && lane0)
    begin
      if (adr_i == `WDT_ADR_CTRL)
      begin
        prescaler_select_q <= dat_i[`WDT_CTRL_PRESEL];
        mode_reset_q <= dat_i[`WDT_CTRL_MODE];
      end
      if (adr_i == `WDT_ADR_PROT)
      begin
        if (dat_i[`WDT_PROT_BIT] && prot_armed_q)
          prot_reg_q <= 1'b1;
        prot_armed_q <= ~dat_i[`WDT_PROT_BIT];
      end
      if (adr_i == `WDT_ADR_REFRESH)
        refresh_armed_q <= (dat_i[7:0] == `WDT_REFRESH_FIRST);
    end
  end

  // Detect flag and interrupt status, set wins over clear
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      detect_q <= 1'b0;
      irq_stat_q <= 2'h0;
      irq_en_q <= 2'h0;
    end
    else
    begin
      if (uflow)
        detect_q <= 1'b1;
      else if (wr && lane0 && adr_i == `WDT_ADR_DETECT && !dat_i[`WDT_DETECT_BIT])
        detect_q <= 1'b0;
      if (wr && lane0 && adr_i == `WDT_ADR_IRQ_EN)
        irq_en_q <= dat_i[1:0];
      irq_stat_q <= (irq_stat_q & ~((wr && lane0 && adr_i == `WDT_ADR_IRQ_CLR) ? dat_i[1:0] : 2'h0))
        | {uflow, tick}; // Bit 1 underflow, bit 0 tick
    end
  end

  // Underflow outcome and interrupt line
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wdt_nmi_o <= 1'b0;
      wdt_reset_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      wdt_reset_o <= uflow & (prot | mode_reset_q);
      wdt_nmi_o <= uflow & ~prot & ~mode_reset_q;
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end

  // Read mux
  always @*
  begin
    cnt_snap = cnt;
    case (adr_i)
      `WDT_ADR_DETECT: dat_o_d = {28'h0, detect_q, 3'h0};
      `WDT_ADR_PROT: dat_o_d = {24'h0, prot, 7'h00};
      `WDT_ADR_CTRL: dat_o_d = {8'h00, 1'b0, cnt_snap, 8'h00} | {24'h0, prescaler_select_q, mode_reset_q, 6'h00};
      `WDT_ADR_IRQ_STAT: dat_o_d = {30'h0, irq_stat_q};
      `WDT_ADR_IRQ_EN: dat_o_d = {30'h0, irq_en_q};
      default: dat_o_d = {31'h0, state_q};
    endcase
  end

  // Single-cycle Wishbone answer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end
    else
    begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= rd ? dat_o_d : 32'h0;
    end
  end
endmodule
`default_nettype wire

// >>> dv/wdt_core_assertions.sv
// Port assertions for the watchdog core
`default_nettype none
module wdt_core_assertions (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire protection_option_bit_i,
  input wire ack_o,
  input wire wdt_nmi_o,
  input wire wdt_reset_o,
  input wire irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Bus answer shape
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  // Underflow and interrupt outputs
  chk_uflow_excl: assert property (!(wdt_nmi_o && wdt_reset_o))
    else $error("interrupt and reset together");
  chk_nmi_gap: assert property (wdt_nmi_o |=> (!wdt_nmi_o && !wdt_reset_o)[*8])
    else $error("underflow repeated without reload");
  chk_rst_gap: assert property (wdt_reset_o |=> !wdt_reset_o[*8])
    else $error("reset pulse repeated");
  chk_prot_no_nmi: assert property (protection_option_bit_i && $past(protection_option_bit_i) |-> !wdt_nmi_o)
    else $error("interrupt while protected");
  chk_start_quiet: assert property ($fell(rst_i) |-> (!wdt_nmi_o && !wdt_reset_o && !irq_o)[*4])
    else $error("event right after reset");
endmodule
bind wdt_core wdt_core_assertions u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .protection_option_bit_i, .ack_o,
  .wdt_nmi_o, .wdt_reset_o, .irq_o);
`default_nettype wire

// >>> dv/wdt_core_test.sv
// Self-checking bench for the watchdog core
`include "wdt_consts.vh"
`default_nettype none
module wdt_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, ack_o, wdt_nmi_o, wdt_reset_o, irq_o;
  logic [2:0] adr_i = 0;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 0, dat_o, rd, seed = 32'h0001548A;
  logic auto_start_option_i = 0, protection_option_bit_i = 0, sub_clock_select_i = 0;
  logic low_speed_osc_clock_i = 0, stop_mode_i = 0, wait_mode_i = 0, bus_hold_i = 0;
  int failures = 0, n_compared = 0, cycles = 0, d, t;
  wdt_core dut (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .auto_start_option_i,
    .protection_option_bit_i, .sub_clock_select_i, .low_speed_osc_clock_i, .stop_mode_i, .wait_mode_i,
    .bus_hold_i, .dat_o, .ack_o, .wdt_nmi_o, .wdt_reset_o, .irq_o);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  always #20 clk_i = ~clk_i;
  // Draw off the rising edge so every reader sees one value
  always @(negedge clk_i) void'(rnd());
  // Cycle count, random slow oscillator, hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    low_speed_osc_clock_i <= seed[0];
    if (cycles == 95000)
    begin
      failures++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic Wishbone cycle, read data taken at the ack edge
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] v);
    we_i <= w;
    adr_i <= a;
    dat_i <= v;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    t = cycles;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Counter drop over n cycles against elapsed/r, r < 0 only measures
  task automatic rate(input int n, input int r);
    int c, t0, e;
    bus(0, `WDT_ADR_CTRL, 0);
    c = rd[22:8];
    t0 = t;
    repeat (n) @(posedge clk_i);
    bus(0, `WDT_ADR_CTRL, 0);
    d = c - int'(rd[22:8]);
    e = (r > 0) ? (t - t0) / r : 0;
    if (r >= 0) check(32'(d >= e - 1 && d <= e + 1), 1);
  endtask
  task automatic print_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (100) @(posedge clk_i);
    bus(0, `WDT_ADR_CTRL, 0);
    check(rd[22:8], `WDT_CNT_RELOAD);
    bus(1, `WDT_ADR_START, seed);
    rate(512, 16);
    bus(1, `WDT_ADR_CTRL, 32'h80);
    rate(2048, 128);
    sub_clock_select_i <= 1'b1;
    rate(64, 2);
    for (int i = 0; i < 3; i++)
    begin
      {bus_hold_i, wait_mode_i, stop_mode_i} <= 3'h1 << i;
      rate(64, 0);
    end
    {bus_hold_i, wait_mode_i, stop_mode_i} <= 3'h0;
    bus(1, `WDT_ADR_DETECT, seed | 32'h8);
    bus(0, `WDT_ADR_DETECT, 0);
    check(rd[3], 0);
    bus(1, `WDT_ADR_IRQ_EN, 32'h2);
    bus(1, `WDT_ADR_CTRL, 32'h0);
    bus(1, `WDT_ADR_REFRESH, 32'h0);
    bus(1, `WDT_ADR_REFRESH, 32'hFF);
    bus(0, `WDT_ADR_CTRL, 0);
    check(32'(`WDT_CNT_RELOAD - rd[22:8] < 15'h0003), 1);
    while (wdt_nmi_o !== 1'b1) @(posedge clk_i);
    check(wdt_reset_o, 0);
    repeat (3) @(posedge clk_i);
    check(irq_o, 1);
    bus(0, `WDT_ADR_DETECT, 0);
    check(rd[3], 1);
    bus(0, `WDT_ADR_CTRL, 0);
    check(32'(`WDT_CNT_RELOAD - rd[22:8] < 15'h00C8), 1);
    bus(1, `WDT_ADR_DETECT, 0);
    bus(1, `WDT_ADR_IRQ_CLR, 32'h2);
    bus(0, `WDT_ADR_DETECT, 0);
    check({rd[3], irq_o}, 0);
    bus(1, `WDT_ADR_PROT, 0);
    bus(1, `WDT_ADR_PROT, 32'h80);
    bus(1, `WDT_ADR_PROT, 0);
    bus(0, `WDT_ADR_PROT, 0);
    check(rd[7], 1);
    stop_mode_i <= 1'b1;
    sub_clock_select_i <= 1'b0;
    rate(1024, -1);
    check(32'(d > 0), 1);
    rst_i <= 1'b1;
    auto_start_option_i <= 1'b1;
    protection_option_bit_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rate(1024, -1);
    check(32'(d > 0), 1);
    print_verdict();
  end
endmodule
`default_nettype wire
